// *** rtl/lrs_pkg.sv ***
/*
  Shared constants of the locomotive refresh scheduler: timing, reset
  defaults, register offsets, field layout and state types.
  Assumes a 200 MHz system clock.
*/
package lrs_pkg;
  // Timing, in the units named
  localparam int CLK_NS        = 5;       // Clock period
  localparam int MS_NS         = 1000000; // One millisecond
  localparam int IDLE_MS       = 120000;  // Zero-speed grace, 2 minutes
  localparam int UNIT_MS       = 20;      // Interval per rate unit
  localparam int CLEAR_HOLD_MS = 100;     // Confirm held before a clear
  // Factory defaults
  localparam logic [7:0] RATE_DEFAULT  = 8'h50; // Update rate 80
  localparam logic [7:0] STEPS_DEFAULT = 8'h1C; // 28 speed steps
  localparam logic [7:0] RATE_ILLEGAL  = 8'h00; // Outside 1..255
  // Register byte offsets
  localparam logic [7:0] REG_RATE   = 8'h00;
  localparam logic [7:0] REG_STEPS  = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_ADDR   = 8'h0C;
  localparam logic [7:0] REG_SPEED  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // Field layout
  localparam int ADDR_W   = 14; // Loco address width
  localparam int FUNC_W   = 5;  // Function bits per loco
  localparam int FUNC_LSB = 8;  // Functions in the speed write
  localparam int SLOT_LSB = 16; // Slot index in addr/speed writes
  localparam int PROG_BIT = 0;  // Programming track busy
  localparam int MSG_BIT  = 16; // Memory-cleared message in status
  typedef enum logic [1:0] {SCH_IDLE, SCH_SCAN, SCH_SEND} lrs_sched_e;
  typedef enum logic [1:0] {CLR_IDLE, CLR_HOLD, CLR_WAIT} lrs_clr_e;
endpackage : lrs_pkg

// *** rtl/lrs_timer.sv ***
/*
  Millisecond prescaler and update-interval timer.
  Assumes an active-low reset whose release is already in step with sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lrs_timer #(
  parameter int TICK_CYCLES = lrs_pkg::MS_NS / lrs_pkg::CLK_NS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] rate,
  output logic            ms_tick,
  output logic            interval_due
);
  logic [17:0] pre_reg, pre_next;  // Cycles within a millisecond
  logic [12:0] ivl_reg, ivl_next;  // Milliseconds within an interval
  logic        tick_reg, tick_next;
  logic        due_reg, due_next;
  logic [12:0] ivl_len;            // Rate times unit, in ms

  // Rate is read live so a change acts at once
  assign ivl_len = 13'(rate * lrs_pkg::UNIT_MS);

  // Next-state of both counters
  always_comb begin
    pre_next  = pre_reg + 18'h00001;
    tick_next = 1'b0;
    ivl_next  = ivl_reg;
    due_next  = 1'b0;
    if (pre_reg >= 18'(TICK_CYCLES - 1)) begin
      pre_next  = 18'h00000;
      tick_next = 1'b1;
      // Compare with >= so a shortened rate fires promptly
      if (ivl_reg + 13'h0001 >= ivl_len) begin
        ivl_next = 13'h0000;
        due_next = 1'b1;
      end else begin
        ivl_next = ivl_reg + 13'h0001;
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= 18'h00000;
      ivl_reg  <= 13'h0000;
      tick_reg <= 1'b0;
      due_reg  <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      ivl_reg  <= ivl_next;
      tick_reg <= tick_next;
      due_reg  <= due_next;
    end
  end

  assign ms_tick      = tick_reg;
  assign interval_due = due_reg;
endmodule : lrs_timer
`default_nettype wire

// *** rtl/lrs_scheduler.sv ***
/*
  Locomotive refresh scheduler: per-throttle slots, periodic round-robin
  packet requests, idle retirement, keypad memory clear, Wishbone slave.
  Assumes a downstream track encoder taking pkt_* on pkt_valid & pkt_ready,
  keypad levels synchronous to sys_clk.
*/
// The Wishbone interface to the registers and the placing of the registers were decided locally.
// How it works
// - Confirm held during reset clears to defaults
// - Clear: no throttles, 28 steps, rate 80
// - Programming track busy blocks mainline packets
// - Active addresses refreshed every update interval
// - Zero speed retires address after two minutes
// - Changing address frees old one at once
// - Rate sets interval between periodic updates
// - New address takes default speed steps
// - Unassigned built-in throttle shows dashes
// - Rate accepts values 1 to 255 only
// - Rate change applies immediately, back to 80 on reset
`timescale 1ns/1ps
`default_nettype none
module lrs_scheduler #(
  parameter int N_SLOTS     = 8,
  parameter int TICK_CYCLES = lrs_pkg::MS_NS / lrs_pkg::CLK_NS,
  parameter int IDLE_MS     = lrs_pkg::IDLE_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        confirm_key,
  input  wire logic        reset_key,
  input  wire logic        pkt_ready,
  output logic             pkt_valid,
  output logic [13:0]      pkt_addr,
  output logic [7:0]       pkt_speed,
  output logic [4:0]       pkt_func,
  output logic [7:0]       pkt_steps,
  output logic             dash_a,
  output logic             dash_b,
  output logic             mem_cleared_msg,
  output logic             defaults_load
);
  localparam int IW = $clog2(N_SLOTS);
  localparam int AW = lrs_pkg::ADDR_W;
  localparam int FW = lrs_pkg::FUNC_W;

  // Reset release through two flops
  logic rst_meta, rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic ms_tick, interval_due;
  logic clear_go;                          // One-cycle memory clear
  logic [7:0] rate_reg, rate_next;         // Update rate
  logic [7:0] steps_reg, steps_next;       // Default speed steps
  logic       prog_reg, prog_next;         // Programming track busy
  logic       ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic       wr, wr_addr, wr_speed;
  logic [IW-1:0] wsel;                     // Slot named by a write
  logic [AW-1:0] s_addr  [N_SLOTS];
  logic [7:0]    s_speed [N_SLOTS];
  logic [FW-1:0] s_func  [N_SLOTS];
  logic [7:0]    s_steps [N_SLOTS];
  logic [N_SLOTS-1:0] s_act;

  lrs_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .rate         (rate_reg),
    .ms_tick      (ms_tick),
    .interval_due (interval_due)
  );

  // Bus decode; a write needs all four byte lanes
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & (&wb_sel_i);
  assign wr_addr  = wr & (wb_adr_i == lrs_pkg::REG_ADDR);
  assign wr_speed = wr & (wb_adr_i == lrs_pkg::REG_SPEED);
  assign wsel     = wb_dat_i[lrs_pkg::SLOT_LSB +: IW];

  // Wishbone slave and configuration registers
  always_comb begin
    ack_next   = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next  = 32'h00000000;  // Unmapped and write-only read zero
    rate_next  = rate_reg;
    steps_next = steps_reg;
    prog_next  = prog_reg;
    case (wb_adr_i)
      lrs_pkg::REG_RATE:   rdat_next[7:0] = rate_reg;
      lrs_pkg::REG_STEPS:  rdat_next[7:0] = steps_reg;
      lrs_pkg::REG_CTRL:   rdat_next[lrs_pkg::PROG_BIT] = prog_reg;
      lrs_pkg::REG_STATUS: begin
        rdat_next[N_SLOTS-1:0]        = s_act;
        rdat_next[lrs_pkg::MSG_BIT]   = mem_cleared_msg;
      end
      default: rdat_next = 32'h00000000;
    endcase
    if (wr) begin
      // Zero is outside the legal range and is dropped
      if (wb_adr_i == lrs_pkg::REG_RATE && wb_dat_i[7:0] != lrs_pkg::RATE_ILLEGAL)
        rate_next = wb_dat_i[7:0];
      if (wb_adr_i == lrs_pkg::REG_STEPS) steps_next = wb_dat_i[7:0];
      if (wb_adr_i == lrs_pkg::REG_CTRL)  prog_next = wb_dat_i[lrs_pkg::PROG_BIT];
    end
    if (clear_go) begin
      rate_next  = lrs_pkg::RATE_DEFAULT;
      steps_next = lrs_pkg::STEPS_DEFAULT;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdat_reg  <= 32'h00000000;
      rate_reg  <= lrs_pkg::RATE_DEFAULT;
      steps_reg <= lrs_pkg::STEPS_DEFAULT;
      prog_reg  <= 1'b0;
    end else begin
      ack_reg   <= ack_next;
      rdat_reg  <= rdat_next;
      rate_reg  <= rate_next;
      steps_reg <= steps_next;
      prog_reg  <= prog_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // One slot per throttle
  genvar gi;
  generate
    for (gi = 0; gi < N_SLOTS; gi++) begin : g_slot
      logic [AW-1:0] a_reg, a_next;
      logic [7:0]    sp_reg, sp_next, st_reg, st_next;
      logic [FW-1:0] f_reg, f_next;
      logic          act_reg, act_next;
      logic [16:0]   idl_reg, idl_next;   // Ms spent at zero speed
      always_comb begin
        a_next = a_reg; sp_next = sp_reg; st_next = st_reg;
        f_next = f_reg; act_next = act_reg; idl_next = idl_reg;
        if (clear_go) begin
          a_next = '0; sp_next = 8'h00; f_next = '0;
          act_next = 1'b0; idl_next = 17'h00000;
        end else if (wr_addr && wsel == IW'(gi)) begin
          // Old address is dropped now, not after the grace time
          a_next   = wb_dat_i[AW-1:0];
          st_next  = steps_reg;
          sp_next  = 8'h00; f_next = '0;
          act_next = 1'b0; idl_next = 17'h00000;
        end else if (wr_speed && wsel == IW'(gi)) begin
          sp_next = wb_dat_i[7:0];
          f_next  = wb_dat_i[lrs_pkg::FUNC_LSB +: FW];
          if (wb_dat_i[7:0] != 8'h00 && a_reg != '0) begin
            act_next = 1'b1; idl_next = 17'h00000;
          end
        end else if (ms_tick && act_reg && sp_reg == 8'h00) begin
          if (idl_reg >= 17'(IDLE_MS - 1)) begin
            act_next = 1'b0; idl_next = 17'h00000;
          end else begin
            idl_next = idl_reg + 17'h00001;
          end
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          a_reg <= '0; sp_reg <= 8'h00; f_reg <= '0;
          st_reg <= lrs_pkg::STEPS_DEFAULT; act_reg <= 1'b0; idl_reg <= 17'h00000;
        end else begin
          a_reg <= a_next; sp_reg <= sp_next; f_reg <= f_next;
          st_reg <= st_next; act_reg <= act_next; idl_reg <= idl_next;
        end
      end
      assign s_addr[gi]  = a_reg;
      assign s_speed[gi] = sp_reg;
      assign s_func[gi]  = f_reg;
      assign s_steps[gi] = st_reg;
      assign s_act[gi]   = act_reg;
    end
  endgenerate

  // Round-robin refresh state
  lrs_pkg::lrs_sched_e sch_reg, sch_next;
  logic [IW-1:0] idx_reg, idx_next;
  logic pend_reg, pend_next;               // Sweep waiting to start
  logic pv_next;
  logic [AW-1:0] pa_next;
  logic [7:0] ps_next, pst_next;
  logic [FW-1:0] pf_next;

  always_comb begin
    sch_next = sch_reg; idx_next = idx_reg;
    pv_next = pkt_valid; pa_next = pkt_addr; ps_next = pkt_speed;
    pf_next = pkt_func; pst_next = pkt_steps;
    pend_next = pend_reg | interval_due;   // A new interval wins
    case (sch_reg)
      lrs_pkg::SCH_IDLE: begin
        // Mainline waits while the programming track is busy
        if (pend_reg && !prog_reg) begin
          sch_next = lrs_pkg::SCH_SCAN;
          idx_next = '0;
          pend_next = interval_due;
        end
      end
      lrs_pkg::SCH_SCAN: begin
        if (!prog_reg) begin
          if (s_act[idx_reg]) begin
            pv_next = 1'b1; pa_next = s_addr[idx_reg];
            ps_next = s_speed[idx_reg]; pf_next = s_func[idx_reg];
            pst_next = s_steps[idx_reg];
            sch_next = lrs_pkg::SCH_SEND;
          end else if (idx_reg == IW'(N_SLOTS - 1)) begin
            sch_next = lrs_pkg::SCH_IDLE;
          end else begin
            idx_next = idx_reg + 1'b1;
          end
        end
      end
      lrs_pkg::SCH_SEND: begin
        if (pkt_ready) begin
          pv_next = 1'b0;
          if (idx_reg == IW'(N_SLOTS - 1)) sch_next = lrs_pkg::SCH_IDLE;
          else begin
            idx_next = idx_reg + 1'b1;
            sch_next = lrs_pkg::SCH_SCAN;
          end
        end
      end
      default: sch_next = lrs_pkg::SCH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sch_reg <= lrs_pkg::SCH_IDLE; idx_reg <= '0; pend_reg <= 1'b0;
      pkt_valid <= 1'b0; pkt_addr <= '0; pkt_speed <= 8'h00;
      pkt_func <= '0; pkt_steps <= 8'h00;
    end else begin
      sch_reg <= sch_next; idx_reg <= idx_next; pend_reg <= pend_next;
      pkt_valid <= pv_next; pkt_addr <= pa_next; pkt_speed <= ps_next;
      pkt_func <= pf_next; pkt_steps <= pst_next;
    end
  end

  // Keypad memory clear and display flags
  lrs_pkg::lrs_clr_e clr_reg, clr_next;
  logic [6:0] hold_reg, hold_next;        // Ms confirm has been held
  logic msg_next, dl_next;
  assign clear_go = defaults_load;

  always_comb begin
    clr_next = clr_reg; hold_next = hold_reg; dl_next = 1'b0;
    msg_next = mem_cleared_msg;
    case (clr_reg)
      lrs_pkg::CLR_IDLE: begin
        if (reset_key && confirm_key) begin
          clr_next = lrs_pkg::CLR_HOLD; hold_next = 7'h00;
        end else if (reset_key) msg_next = 1'b0;
      end
      lrs_pkg::CLR_HOLD: begin
        if (!confirm_key) clr_next = lrs_pkg::CLR_IDLE;
        else if (ms_tick) begin
          if (hold_reg >= 7'(lrs_pkg::CLEAR_HOLD_MS - 1)) begin
            dl_next = 1'b1; msg_next = 1'b1;
            clr_next = lrs_pkg::CLR_WAIT;
          end else hold_next = hold_reg + 7'h01;
        end
      end
      lrs_pkg::CLR_WAIT: begin
        // Rearm only after both keys are released
        if (!confirm_key && !reset_key) clr_next = lrs_pkg::CLR_IDLE;
      end
      default: clr_next = lrs_pkg::CLR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_reg <= lrs_pkg::CLR_IDLE; hold_reg <= 7'h00;
      defaults_load <= 1'b0; mem_cleared_msg <= 1'b0;
      dash_a <= 1'b1; dash_b <= 1'b1;
    end else begin
      clr_reg <= clr_next; hold_reg <= hold_next;
      defaults_load <= dl_next; mem_cleared_msg <= msg_next;
      dash_a <= (s_addr[0] == '0);
      dash_b <= (s_addr[1] == '0);
    end
  end

  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_rate_zero_drop: assert property (
    wr && wb_adr_i == lrs_pkg::REG_RATE && wb_dat_i[7:0] == 8'h00 && !clear_go
    |=> rate_reg == $past(rate_reg)) else $error("rate 0 taken");
  // Defaults land on the edge that ends the load pulse
  a_clear_defaults: assert property (
    clear_go |=> rate_reg == lrs_pkg::RATE_DEFAULT && steps_reg == lrs_pkg::STEPS_DEFAULT
    && s_act == '0) else $error("defaults missing");
  a_clear_message: assert property (
    $rose(defaults_load) |-> mem_cleared_msg) else $error("no message");
  a_clear_abort: assert property (
    clr_reg == lrs_pkg::CLR_HOLD && !confirm_key
    |=> !defaults_load && clr_reg == lrs_pkg::CLR_IDLE) else $error("abort ignored");
  a_prog_blocks: assert property (
    prog_reg && !pkt_valid |=> !pkt_valid) else $error("sent while programming");
  a_pkt_is_active: assert property (
    $rose(pkt_valid) |-> pkt_addr != '0) else $error("inactive refreshed");
  a_new_steps: assert property (
    wr_addr && !clear_go && wsel == '0
    |=> s_steps[0] == $past(steps_reg)) else $error("steps not default");
  a_dash_blank: assert property (
    s_addr[0] == '0 |=> dash_a) else $error("no dashes");
  c_clear_done: cover property (defaults_load);
  c_pkt_sent: cover property (pkt_valid && pkt_ready);
  c_retired: cover property ($fell(s_act[0]));
  c_prog_stall: cover property (prog_reg && pend_reg);
endmodule : lrs_scheduler
`default_nettype wire

// *** tb/lrs_track_model.sv ***
/*
  Track-side partner: a packet sink standing in for the decoders.
  Assumes pkt_* from the scheduler on sys_clk; ready is a level.
*/
`timescale 1ns/1ps
`default_nettype none
module lrs_track_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        pkt_valid,
  input  wire logic [13:0] pkt_addr,
  input  wire logic [7:0]  pkt_speed,
  input  wire logic [4:0]  pkt_func,
  input  wire logic [7:0]  pkt_steps,
  output logic             pkt_ready,
  output int               got,
  output logic [13:0]      last_addr,
  output logic [7:0]       last_speed,
  output logic [4:0]       last_func,
  output logic [7:0]       last_steps
);
  logic [1:0] wait_reg;  // Cycles stalled so far
  logic [1:0] wait_next;
  logic       rdy_next;
  // Slow mode stalls four cycles so the hold path gets exercised
  always_comb begin
    wait_next = 2'h0;
    rdy_next  = 1'b0;
    if (pkt_valid && !pkt_ready) begin
      wait_next = wait_reg + 2'h1;
      rdy_next  = !slow || (wait_reg == 2'h3);
    end
  end
  // Accept on valid and ready, then keep the packet for the bench
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_ready <= 1'b0;
      wait_reg  <= 2'h0;
      got       <= 0;
    end else begin
      pkt_ready <= rdy_next;
      wait_reg  <= wait_next;
      if (pkt_valid && pkt_ready) begin
        got        <= got + 1;
        last_addr  <= pkt_addr;
        last_speed <= pkt_speed;
        last_func  <= pkt_func;
        last_steps <= pkt_steps;
      end
    end
  end
endmodule : lrs_track_model
`default_nettype wire

// *** tb/tb.sv ***
/*
  Self-checking bench for the refresh scheduler: register rows, packet
  timing, programming hold, retirement and keypad clear.
  Assumes the track model answers on the packet port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TICK = 10;  // Cycles per ms, shortened
  localparam int IDLE = 50;  // Zero-speed grace in ms, shortened
  // Keypad hold window seen from key press; tick phase gives the spread
  localparam int HOLD_MIN = (lrs_pkg::CLEAR_HOLD_MS - 1) * TICK;
  localparam int HOLD_MAX = lrs_pkg::CLEAR_HOLD_MS * TICK + 2;
  typedef struct packed {
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wd;
    logic [31:0] rd;
  } lrs_row_s;
  logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, confirm_key, reset_key, slow;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        wb_ack_o, pkt_ready, pkt_valid, dash_a, dash_b, mem_cleared_msg, defaults_load;
  logic [13:0] pkt_addr, l_addr;
  logic [7:0]  pkt_speed, pkt_steps, l_speed, l_steps;
  logic [4:0]  pkt_func, l_func;
  int          got, fails, comparisons, k, t0;
  int          cycles = 0;  // Only the hang guard writes it
  // Written, then read back; zero rate and partial lanes must not land
  lrs_row_s rows [8] = '{
    '{lrs_pkg::REG_RATE, 4'hF, 32'h0000_00FF, 32'h0000_00FF},
    '{lrs_pkg::REG_RATE, 4'hF, 32'h0000_0000, 32'h0000_00FF},
    '{lrs_pkg::REG_RATE, 4'hF, 32'h0000_0001, 32'h0000_0001},
    '{lrs_pkg::REG_STEPS, 4'hF, 32'h0000_000E, 32'h0000_000E},
    '{lrs_pkg::REG_STEPS, 4'h1, 32'h0000_0080, 32'h0000_000E},
    '{lrs_pkg::REG_CTRL, 4'hF, 32'h0000_0001, 32'h0000_0001},
    '{lrs_pkg::REG_CTRL, 4'hF, 32'h0000_0000, 32'h0000_0000},
    '{8'h40, 4'hF, 32'h0000_005A, 32'h0000_0000}};

  lrs_scheduler #(.TICK_CYCLES(TICK), .IDLE_MS(IDLE)) i_dut (
    .sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .confirm_key, .reset_key, .pkt_ready, .pkt_valid, .pkt_addr,
    .pkt_speed, .pkt_func, .pkt_steps, .dash_a, .dash_b, .mem_cleared_msg, .defaults_load
  );
  lrs_track_model i_track (
    .sys_clk, .nrst, .slow, .pkt_valid, .pkt_addr, .pkt_speed, .pkt_func, .pkt_steps,
    .pkt_ready, .got, .last_addr(l_addr), .last_speed(l_speed), .last_func(l_func),
    .last_steps(l_steps)
  );

  // Free-running 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // No cycle count assumed; only the hang guard ends this wait
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("wb_ack", 32'(wb_ack_o), 32'h1);
  endtask : wb

  // Waits, bounded, for the model to take one more packet
  task automatic next_pkt;
    int n0;
    int n;
    n0 = got;
    n = 0;
    while (got == n0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pkt_seen", 32'(got - n0), 32'h1);
  endtask : next_pkt

  task automatic end_sim;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    confirm_key = 1'b0;
    reset_key = 1'b0;
    slow = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("idle_outs", 32'({dash_a, dash_b, pkt_valid, mem_cleared_msg}), 32'hC);
    wb(1'b0, lrs_pkg::REG_RATE, 4'hF, 32'h0);
    chk("rate_rst", rdat, 32'(lrs_pkg::RATE_DEFAULT));
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].sel, rows[i].wd);
      wb(1'b0, rows[i].adr, 4'hF, 32'h0);
      chk("row_read", rdat, rows[i].rd);
    end
    // Slot 0: address 3, speed 5, functions 3, steps from the default
    wb(1'b1, lrs_pkg::REG_ADDR, 4'hF, 32'h0000_0003);
    wb(1'b1, lrs_pkg::REG_SPEED, 4'hF, 32'h0000_0305);
    chk("dash_a", 32'(dash_a), 32'h0);
    next_pkt();
    chk("pkt_addr", 32'(l_addr), 32'h3);
    chk("pkt_data", 32'({l_speed, 3'h0, l_func, l_steps}), 32'h0005_030E);
    // Interval follows the rate; first two gaps after a change are skipped
    for (int r = 1; r <= 2; r++) begin
      wb(1'b1, lrs_pkg::REG_RATE, 4'hF, 32'(r));
      next_pkt();
      next_pkt();
      t0 = cycles;
      next_pkt();
      chk("gap", 32'(cycles - t0), 32'(r * lrs_pkg::UNIT_MS * TICK));
    end
    wb(1'b1, lrs_pkg::REG_RATE, 4'hF, 32'h1);
    // Two slots under a stalling encoder keep round-robin order
    wb(1'b1, lrs_pkg::REG_ADDR, 4'hF, 32'h0001_0007);
    wb(1'b1, lrs_pkg::REG_SPEED, 4'hF, 32'h0001_0109);
    chk("dash_b", 32'(dash_b), 32'h0);
    slow <= 1'b1;
    next_pkt();
    k = int'(l_addr);
    next_pkt();
    chk("rr_order", 32'(l_addr), (k == 3) ? 32'h7 : 32'h3);
    slow <= 1'b0;
    // Programming track busy: nothing new for over two intervals
    wb(1'b1, lrs_pkg::REG_CTRL, 4'hF, 32'h1);
    repeat (3) @(posedge sys_clk);
    k = got;
    repeat (450) @(posedge sys_clk);
    chk("prog_hold", 32'(got - k), 32'h0);
    wb(1'b1, lrs_pkg::REG_CTRL, 4'hF, 32'h0);
    next_pkt();
    // Moving slot 1 to a new address frees the old one at once
    wb(1'b1, lrs_pkg::REG_ADDR, 4'hF, 32'h0001_0009);
    wb(1'b0, lrs_pkg::REG_STATUS, 4'hF, 32'h0);
    chk("moved", rdat, 32'h1);
    // Zero speed: still refreshed, retired after the grace time
    wb(1'b1, lrs_pkg::REG_SPEED, 4'hF, 32'h0);
    t0 = cycles;
    next_pkt();
    chk("idle_spd", 32'(l_speed), 32'h0);
    while (cycles - t0 < 460) @(posedge sys_clk);
    wb(1'b0, lrs_pkg::REG_STATUS, 4'hF, 32'h0);
    chk("idle_keep", rdat, 32'h1);
    while (cycles - t0 < 540) @(posedge sys_clk);
    wb(1'b0, lrs_pkg::REG_STATUS, 4'hF, 32'h0);
    chk("idle_drop", rdat, 32'h0);
    // Confirm let go early: no clear
    confirm_key <= 1'b1;
    reset_key <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset_key <= 1'b0;
    repeat (500) @(posedge sys_clk);
    confirm_key <= 1'b0;
    repeat (700) @(posedge sys_clk);
    chk("abort_msg", 32'(mem_cleared_msg), 32'h0);
    wb(1'b0, lrs_pkg::REG_RATE, 4'hF, 32'h0);
    chk("abort_rate", rdat, 32'h1);
    // Confirm held through: clear after the hold time
    confirm_key <= 1'b1;
    reset_key <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset_key <= 1'b0;
    k = 0;
    while (mem_cleared_msg !== 1'b1 && k < 1200) begin
      @(posedge sys_clk);
      k++;
    end
    chk("load_pulse", 32'(defaults_load), 32'h1);
    t0 = k + 5;  // Cycles since the keys went down
    chk("hold_time", 32'(t0 >= HOLD_MIN && t0 <= HOLD_MAX), 32'h1);
    confirm_key <= 1'b0;
    wb(1'b0, lrs_pkg::REG_RATE, 4'hF, 32'h0);
    chk("clr_rate", rdat, 32'(lrs_pkg::RATE_DEFAULT));
    wb(1'b0, lrs_pkg::REG_STEPS, 4'hF, 32'h0);
    chk("clr_steps", rdat, 32'(lrs_pkg::STEPS_DEFAULT));
    wb(1'b0, lrs_pkg::REG_STATUS, 4'hF, 32'h0);
    chk("clr_status", rdat, 32'h0001_0000);
    chk("clr_dash", 32'({dash_a, dash_b}), 32'h3);
    end_sim();
  end
endmodule : tb
`default_nettype wire
